// *** hdl/wdtrc_pkg.sv ***
package wdtrc_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] WDT_CTRL_OFFS    = 8'h60;
   localparam logic [7:0] RST_CAUSE_OFFS   = 8'h64;

   // Watchdog control/status fields
   localparam int         IRQ_FLAG_BIT     = 7;
   localparam int         IRQ_EN_BIT       = 6;
   localparam int         SEL_HI_BIT       = 5;
   localparam int         UNLOCK_BIT       = 4;
   localparam int         RST_EN_BIT       = 3;
   localparam int         SEL_LO_MSB       = 2;
   localparam logic [7:0] WDT_CTRL_RESET   = 8'h00;

   // Reset cause fields
   localparam int         DEBUG_FLAG_BIT   = 4;
   localparam int         WDOG_FLAG_BIT    = 3;
   localparam int         DROP_FLAG_BIT    = 2;
   localparam int         PIN_FLAG_BIT     = 1;
   localparam int         POWER_FLAG_BIT   = 0;
   localparam logic [4:0] RST_CAUSE_RESET  = 5'h01;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int         UNLOCK_CYCLES    = 4;
   localparam int         OSC_FREQ_KHZ     = 128;
   localparam int         BASE_OSC_CYCLES  = 2048;
   localparam int         LAST_SEL_CODE    = 9;
   localparam int         TOUT_CNT_W       = 20;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic debug_port;
      logic supply_drop;
      logic pin;
      logic power_up;
   } wdtrc_rst_src_s;

endpackage

// *** hdl/wdtrc_osc_sync.sv ***
`timescale 1ns/10ps
module wdtrc_osc_sync (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Oscillator level in, one pulse per rising edge out
   input  wire logic osc_in,
   output logic      osc_tick_q
);

   // ****************************************************************
   // Two-stage synchroniser, then edge detect on the second stage
   // ****************************************************************
   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q     <= 1'b0;
         sync_q     <= 1'b0;
         prev_q     <= 1'b0;
         osc_tick_q <= 1'b0;
      end else begin
         meta_q     <= osc_in;
         sync_q     <= meta_q;
         prev_q     <= sync_q;
         osc_tick_q <= sync_q & ~prev_q;
      end
   end

endmodule

// *** hdl/wdtrc_counter.sv ***
`timescale 1ns/10ps
module wdtrc_counter #(
   parameter int BASE_CYCLES = wdtrc_pkg::BASE_OSC_CYCLES,
   parameter int CNT_W       = wdtrc_pkg::TOUT_CNT_W
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       osc_tick,
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [3:0] sel,
   // Event
   output logic            timeout_q
);

   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] last;
   logic [3:0]       sel_eff;

   // Reserved codes clamp to the longest period rather than stopping
   always_comb begin
      sel_eff = (sel > 4'(wdtrc_pkg::LAST_SEL_CODE)) ? 4'(wdtrc_pkg::LAST_SEL_CODE) : sel;
      last    = CNT_W'((BASE_CYCLES << sel_eff) - 1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q   <= '0;
         timeout_q <= 1'b0;
      end else begin
         timeout_q <= 1'b0;
         if (restart || !run) begin
            count_q <= '0;
         end else if (osc_tick) begin
            // Compare with >= so a shorter period still ends the count
            if (count_q >= last) begin
               count_q   <= '0;
               timeout_q <= 1'b1;
            end else begin
               count_q <= count_q + CNT_W'(1);
            end
         end
      end
   end

endmodule

// *** hdl/wdtrc_top.sv ***
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module wdtrc_top #(
   parameter int BASE_CYCLES = wdtrc_pkg::BASE_OSC_CYCLES
) (
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Watchdog oscillator
   input  wire logic                     wdt_osc,
   // Processor side
   input  wire logic                     global_irq_en,
   input  wire logic                     irq_vector_ack,
   input  wire logic                     wdt_restart,
   input  wire logic                     always_on_fuse,
   // Other reset sources, one-cycle pulses
   input  wire wdtrc_pkg::wdtrc_rst_src_s rst_src,
   // Outputs
   output logic                          wdt_irq,
   output logic                          wdt_sys_reset
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        irq_flag_q;
   logic        irq_en_q;
   logic        rst_en_q;
   logic        unlock_q;
   logic [1:0]  unlock_cnt_q;
   logic [3:0]  sel_q;
   logic [4:0]  cause_q;
   logic [4:0]  cause_d;
   logic        wdt_irq_q;
   logic        wdt_sys_reset_q;
   logic        osc_tick;
   logic        timeout;
   logic        setup;
   logic        wr_acc;
   logic        wr_ctrl;
   logic        wr_cause;
   logic        unlock_write;
   logic        fuse_prog;
   logic        rst_en_eff;
   logic        irq_en_eff;
   logic        tout_irq;
   logic        tout_rst;
   logic        combined;
   logic [7:0]  ctrl_rd;

   // ****************************************************************
   // Decode and mode
   // ****************************************************************
   assign setup        = psel & ~penable;
   assign wr_acc       = psel & penable & pready_q & pwrite;
   assign wr_ctrl      = wr_acc & (paddr == wdtrc_pkg::WDT_CTRL_OFFS);
   assign wr_cause     = wr_acc & (paddr == wdtrc_pkg::RST_CAUSE_OFFS);
   assign unlock_write = wr_ctrl & pwdata[wdtrc_pkg::UNLOCK_BIT] & pwdata[wdtrc_pkg::RST_EN_BIT];

   assign fuse_prog  = ~always_on_fuse;
   assign rst_en_eff = rst_en_q | cause_q[wdtrc_pkg::WDOG_FLAG_BIT] | fuse_prog;
   assign irq_en_eff = irq_en_q & ~fuse_prog;
   assign combined   = rst_en_eff & irq_en_eff;

   // Mode table: irq only, reset only, irq then reset
   assign tout_irq = timeout & irq_en_eff & ~(rst_en_eff & irq_flag_q);
   assign tout_rst = timeout & rst_en_eff & (~irq_en_eff | irq_flag_q);

   assign ctrl_rd = {irq_flag_q, irq_en_eff, sel_q[3], unlock_q,
                     rst_en_eff, sel_q[2:0]};

   // ****************************************************************
   // Oscillator and counter
   // ****************************************************************
   wdtrc_osc_sync u_sync (
      .pclk       (pclk),
      .presetn    (presetn),
      .osc_in     (wdt_osc),
      .osc_tick_q (osc_tick)
   );

   wdtrc_counter #(
      .BASE_CYCLES (BASE_CYCLES),
      .CNT_W       (wdtrc_pkg::TOUT_CNT_W)
   ) u_counter (
      .pclk      (pclk),
      .presetn   (presetn),
      .osc_tick  (osc_tick),
      .run       (rst_en_eff | irq_en_eff),
      .restart   (wdt_restart),
      .sel       (sel_q),
      .timeout_q (timeout)
   );

   // ****************************************************************
   // APB slave: one wait-free access phase, read data captured at setup
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= 1'b0;
         // State read at setup keeps pready registered with no wait state
         if (setup) begin
            unique case (paddr)
               wdtrc_pkg::WDT_CTRL_OFFS:  prdata_q <= {24'h00_0000, ctrl_rd};
               wdtrc_pkg::RST_CAUSE_OFFS: prdata_q <= {27'h000_0000, cause_q};
               default: begin
                  prdata_q  <= 32'h0000_0000;
                  pslverr_q <= 1'b1;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Timed unlock window
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_q     <= wdtrc_pkg::WDT_CTRL_RESET[wdtrc_pkg::UNLOCK_BIT];
         unlock_cnt_q <= 2'h0;
      end else if (unlock_write) begin
         unlock_q     <= 1'b1;
         unlock_cnt_q <= 2'(wdtrc_pkg::UNLOCK_CYCLES - 1);
      end else if (wr_ctrl) begin
         unlock_q <= 1'b0;
      end else if (unlock_q) begin
         if (unlock_cnt_q == 2'h0) begin
            unlock_q <= 1'b0;
         end else begin
            unlock_cnt_q <= unlock_cnt_q - 2'h1;
         end
      end
   end

   // ****************************************************************
   // Control fields
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_en_q <= wdtrc_pkg::WDT_CTRL_RESET[wdtrc_pkg::RST_EN_BIT];
      end else if (cause_q[wdtrc_pkg::WDOG_FLAG_BIT]) begin
         rst_en_q <= 1'b1;
      end else if (wr_ctrl && pwdata[wdtrc_pkg::RST_EN_BIT]) begin
         rst_en_q <= 1'b1;
      end else if (wr_ctrl && unlock_q) begin
         rst_en_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= {wdtrc_pkg::WDT_CTRL_RESET[wdtrc_pkg::SEL_HI_BIT],
                   wdtrc_pkg::WDT_CTRL_RESET[wdtrc_pkg::SEL_LO_MSB:0]};
      end else if (wr_ctrl && unlock_q) begin
         sel_q <= {pwdata[wdtrc_pkg::SEL_HI_BIT], pwdata[wdtrc_pkg::SEL_LO_MSB:0]};
      end
   end

   // Handler entry drops the enable only in combined mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_q <= wdtrc_pkg::WDT_CTRL_RESET[wdtrc_pkg::IRQ_EN_BIT];
      end else if (wr_ctrl) begin
         irq_en_q <= pwdata[wdtrc_pkg::IRQ_EN_BIT];
      end else if (irq_vector_ack && combined) begin
         irq_en_q <= 1'b0;
      end
   end

   // A time-out in the same cycle as a clear keeps the flag set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_q <= wdtrc_pkg::WDT_CTRL_RESET[wdtrc_pkg::IRQ_FLAG_BIT];
      end else if (tout_irq) begin
         irq_flag_q <= 1'b1;
      end else if (irq_vector_ack || (wr_ctrl && pwdata[wdtrc_pkg::IRQ_FLAG_BIT])) begin
         irq_flag_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Reset cause flags
   // ****************************************************************
   always_comb begin
      cause_d = cause_q;
      if (wr_cause) begin
         cause_d = cause_q & pwdata[4:0];
      end
      if (rst_src.power_up) begin
         cause_d = 5'h00;
      end
      // Sets come last so they win over any clear
      if (rst_src.power_up) begin
         cause_d[wdtrc_pkg::POWER_FLAG_BIT] = 1'b1;
      end
      if (rst_src.debug_port) begin
         cause_d[wdtrc_pkg::DEBUG_FLAG_BIT] = 1'b1;
      end
      if (tout_rst) begin
         cause_d[wdtrc_pkg::WDOG_FLAG_BIT] = 1'b1;
      end
      if (rst_src.supply_drop) begin
         cause_d[wdtrc_pkg::DROP_FLAG_BIT] = 1'b1;
      end
      if (rst_src.pin) begin
         cause_d[wdtrc_pkg::PIN_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= wdtrc_pkg::RST_CAUSE_RESET;
      end else begin
         cause_q <= cause_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_irq_q       <= 1'b0;
         wdt_sys_reset_q <= 1'b0;
      end else begin
         wdt_irq_q       <= irq_flag_q & irq_en_eff & global_irq_en;
         wdt_sys_reset_q <= tout_rst;
      end
   end

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign wdt_irq       = wdt_irq_q;
   assign wdt_sys_reset = wdt_sys_reset_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_unlock_idle;
      unlock_write ##1 (!wr_ctrl)[*4];
   endsequence

   sequence s_combined_pending;
      timeout && irq_flag_q && combined;
   endsequence

   // A vector taken in the cycle of a new time-out leaves the flag set
   sequence s_vector_taken;
      irq_vector_ack && !tout_irq;
   endsequence

   sequence s_power_only;
      rst_src.power_up && !rst_src.debug_port && !rst_src.supply_drop
      && !rst_src.pin && !tout_rst;
   endsequence

   a_unlock_open:  assert property (unlock_write |=> unlock_q)
      else $error("unlock bit not set after unlock write");
   a_unlock_close: assert property (s_unlock_idle |=> !unlock_q)
      else $error("unlock window longer than four cycles");
   a_select_lock:  assert property (wr_ctrl && !unlock_q |=> $stable(sel_q))
      else $error("select changed while locked");
   a_rst_en_held:  assert property (wr_ctrl && cause_q[wdtrc_pkg::WDOG_FLAG_BIT]
                                    |=> ctrl_rd[wdtrc_pkg::RST_EN_BIT])
      else $error("reset enable cleared while watchdog flag set");
   a_fuse_reset:   assert property (fuse_prog && timeout
                                    |=> wdt_sys_reset_q && !$rose(irq_flag_q))
      else $error("programmed fuse did not give reset");
   a_irq_gate:     assert property (wdt_irq_q
                                    |-> $past(irq_flag_q && irq_en_eff && global_irq_en))
      else $error("interrupt without flag, enable and global enable");
   a_irq_flag_set: assert property (timeout && irq_en_eff && !rst_en_eff |=> irq_flag_q)
      else $error("time-out did not set interrupt flag");
   a_ack_fallback: assert property (irq_vector_ack && combined && !timeout && !wr_ctrl
                                    |=> !irq_flag_q && !irq_en_q)
      else $error("vector did not fall back to reset mode");
   a_vector_clear: assert property (s_vector_taken |=> !irq_flag_q)
      else $error("vector did not clear interrupt flag");
   a_irq_request:  assert property (irq_flag_q && irq_en_eff && global_irq_en
                                    |=> wdt_irq_q)
      else $error("interrupt not requested with flag and enables set");
   a_rst_en_lock:  assert property (wr_ctrl && !unlock_q |=> !$fell(rst_en_q))
      else $error("reset enable cleared while locked");
   a_restart_clr:  assert property (wdt_restart |=> !timeout)
      else $error("time-out right after restart");
   a_power_flag:   assert property (s_power_only
                                    |=> cause_q == wdtrc_pkg::RST_CAUSE_RESET)
      else $error("power-up did not leave only its own flag");
   a_cause_write:  assert property (wr_cause && !(|rst_src) && !tout_rst
                                    |=> cause_q == ($past(cause_q) & $past(pwdata[4:0])))
      else $error("cause write did not clear the zero bits");
   a_second_tout:  assert property (s_combined_pending |=> wdt_sys_reset_q ##1 !wdt_sys_reset_q)
      else $error("pending interrupt time-out gave no reset");
   a_wdog_flag:    assert property (wdt_sys_reset_q |-> cause_q[wdtrc_pkg::WDOG_FLAG_BIT])
      else $error("watchdog reset without cause flag");
   a_reset_pulse:  assert property (wdt_sys_reset_q |=> !wdt_sys_reset_q)
      else $error("reset pulse longer than one cycle");

endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic                      pclk, presetn, psel, penable, pwrite;
   logic                      wdt_osc, global_irq_en, irq_vector_ack;
   logic                      wdt_restart, always_on_fuse;
   logic                      pready, pslverr, wdt_irq, wdt_sys_reset;
   logic [7:0]                paddr;
   logic [31:0]               pwdata, prdata;
   logic [2:0]                osc_cnt;
   logic [3:0]                cv;
   logic [33:0]               exp_e;
   logic [33:0]               exp_q[$];
   wdtrc_pkg::wdtrc_rst_src_s rst_src;
   int                        failures, checks_done, n;

   wdtrc_top #(.BASE_CYCLES(4)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wdt_osc(wdt_osc), .global_irq_en(global_irq_en), .irq_vector_ack(irq_vector_ack),
      .wdt_restart(wdt_restart), .always_on_fuse(always_on_fuse), .rst_src(rst_src),
      .wdt_irq(wdt_irq), .wdt_sys_reset(wdt_sys_reset));

   // ****************************************************************
   // Clocks
   // ****************************************************************
   initial pclk = 1'b0;
   always #20 pclk = ~pclk;

   // Oscillator period of 8 system cycles keeps the 2-flop sampler honest
   always @(posedge pclk) begin
      osc_cnt <= osc_cnt + 3'h1;
      wdt_osc <= osc_cnt[2];
   end

   // ****************************************************************
   // Checking
   // ****************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Oldest note is compared against each completed APB transfer
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(32'h0, 32'h1, "response without request");
         end else begin
            exp_e = exp_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, exp_e[32]}, "pslverr");
            if (exp_e[33]) chk(prdata, {24'h0, exp_e[7:0]}, "prdata");
         end
      end
   end

   // ****************************************************************
   // Drivers
   // ****************************************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] e, input logic err);
      int          k;
      logic [31:0] rnd;
      rnd = $urandom();
      @(posedge pclk);
      exp_q.push_back({~w, err, 24'h0, e});
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {rnd[31:8], d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) chk(32'h0, 32'h1, "no pready");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Bits: vector ack, restart, then reset sources high to low
   task automatic pulse(input logic [5:0] v);
      @(posedge pclk);
      {irq_vector_ack, wdt_restart, rst_src} <= v;
      @(posedge pclk);
      {irq_vector_ack, wdt_restart, rst_src} <= 6'h00;
   endtask

   task automatic wait_ev(input int which, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge pclk);
         cnt++;
      end while (((which == 0) ? wdt_irq : wdt_sys_reset) !== 1'b1 && cnt < lim);
      if (cnt >= lim) chk(32'h0, 32'h1, "event did not come");
   endtask

   task automatic tdone(input string name);
      $display("test %s done, checks %0d", name, checks_done);
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      {presetn, psel, penable, pwrite, global_irq_en} = 5'h00;
      {irq_vector_ack, wdt_restart, rst_src} = 6'h00;
      {paddr, pwdata, osc_cnt, wdt_osc} = '0;
      always_on_fuse = 1'b1;
      failures = 0;
      checks_done = 0;
      void'($urandom(32'h75DD6D08));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h60, 8'h00, 8'h00, 1'b0);
      apb(1'b0, 8'h64, 8'h00, 8'h01, 1'b0);
      apb(1'b1, 8'h64, 8'h00, 8'h00, 1'b0);
      apb(1'b0, 8'h64, 8'h00, 8'h00, 1'b0);
      pulse(6'h08);
      apb(1'b0, 8'h64, 8'h00, 8'h10, 1'b0);
      pulse(6'h04);
      apb(1'b0, 8'h64, 8'h00, 8'h14, 1'b0);
      pulse(6'h02);
      apb(1'b0, 8'h64, 8'h00, 8'h16, 1'b0);
      apb(1'b1, 8'h64, 8'h12, 8'h00, 1'b0);
      apb(1'b0, 8'h64, 8'h00, 8'h12, 1'b0);
      pulse(6'h01);
      apb(1'b0, 8'h64, 8'h00, 8'h01, 1'b0);
      apb(1'b1, 8'h68, 8'hFF, 8'h00, 1'b1);
      apb(1'b0, 8'h68, 8'h00, 8'h00, 1'b1);
      tdone("reset cause");
      apb(1'b1, 8'h60, 8'h18, 8'h00, 1'b0);
      apb(1'b1, 8'h60, 8'h40, 8'h00, 1'b0);
      @(posedge pclk) global_irq_en <= 1'b1;
      wait_ev(0, 100, n);
      @(posedge pclk) global_irq_en <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({31'h0, wdt_irq}, 32'h0, "irq with global off");
      apb(1'b0, 8'h60, 8'h00, 8'hC0, 1'b0);
      pulse(6'h20);
      apb(1'b0, 8'h60, 8'h00, 8'h40, 1'b0);
      @(posedge pclk) global_irq_en <= 1'b1;
      wait_ev(0, 100, n);
      apb(1'b1, 8'h60, 8'hC0, 8'h00, 1'b0);
      apb(1'b0, 8'h60, 8'h00, 8'h40, 1'b0);
      apb(1'b1, 8'h60, 8'h00, 8'h00, 1'b0);
      apb(1'b0, 8'h60, 8'h00, 8'h00, 1'b0);
      tdone("interrupt mode");
      apb(1'b1, 8'h60, 8'h48, 8'h00, 1'b0);
      wait_ev(0, 100, n);
      pulse(6'h20);
      apb(1'b0, 8'h60, 8'h00, 8'h08, 1'b0);
      wait_ev(1, 100, n);
      @(posedge pclk);
      chk({31'h0, wdt_sys_reset}, 32'h0, "reset pulse length");
      apb(1'b0, 8'h64, 8'h00, 8'h09, 1'b0);
      apb(1'b1, 8'h60, 8'h48, 8'h00, 1'b0);
      wait_ev(0, 100, n);
      wait_ev(1, 40, n);
      pulse(6'h20);
      apb(1'b1, 8'h60, 8'h18, 8'h00, 1'b0);
      apb(1'b1, 8'h60, 8'h00, 8'h00, 1'b0);
      apb(1'b0, 8'h60, 8'h00, 8'h08, 1'b0);
      pulse(6'h10);
      apb(1'b1, 8'h64, 8'h00, 8'h00, 1'b0);
      apb(1'b1, 8'h60, 8'h18, 8'h00, 1'b0);
      apb(1'b1, 8'h60, 8'h00, 8'h00, 1'b0);
      apb(1'b0, 8'h60, 8'h00, 8'h00, 1'b0);
      apb(1'b0, 8'h64, 8'h00, 8'h00, 1'b0);
      tdone("combined mode");
      apb(1'b1, 8'h60, 8'h08, 8'h00, 1'b0);
      apb(1'b1, 8'h60, 8'h00, 8'h00, 1'b0);
      apb(1'b0, 8'h60, 8'h00, 8'h08, 1'b0);
      apb(1'b1, 8'h60, 8'h0D, 8'h00, 1'b0);
      apb(1'b0, 8'h60, 8'h00, 8'h08, 1'b0);
      apb(1'b1, 8'h60, 8'h18, 8'h00, 1'b0);
      repeat (6) @(posedge pclk);
      apb(1'b1, 8'h60, 8'h0F, 8'h00, 1'b0);
      apb(1'b0, 8'h60, 8'h00, 8'h08, 1'b0);
      tdone("unlock window");
      for (int c = 0; c < 10; c++) begin
         cv = c[3:0];
         pulse(6'h10);
         apb(1'b1, 8'h60, 8'h18, 8'h00, 1'b0);
         apb(1'b1, 8'h60, {2'b00, cv[3], 2'b01, cv[2:0]}, 8'h00, 1'b0);
         wait_ev(1, 40000, n);
         wait_ev(1, 40000, n);
         chk(n, (4 << c) * 8, "time-out period");
      end
      apb(1'b0, 8'h60, 8'h00, 8'h29, 1'b0);
      tdone("time-out select");
      @(posedge pclk) always_on_fuse <= 1'b0;
      apb(1'b1, 8'h60, 8'h40, 8'h00, 1'b0);
      apb(1'b0, 8'h60, 8'h00, 8'h29, 1'b0);
      pulse(6'h10);
      apb(1'b1, 8'h60, 8'h18, 8'h00, 1'b0);
      apb(1'b1, 8'h60, 8'h48, 8'h00, 1'b0);
      wait_ev(1, 100, n);
      wait_ev(1, 100, n);
      chk(n, 32'h20, "fuse time-out period");
      chk({31'h0, wdt_irq}, 32'h0, "irq with fuse programmed");
      apb(1'b0, 8'h60, 8'h00, 8'h08, 1'b0);
      tdone("fuse");
      end_sim();
   end

   // Longest run is the select sweep, about 70000 cycles
   initial begin
      #(40 * 90000);
      failures++;
      $display("MISMATCH t=%0t watchdog of the bench ran out", $time);
      end_sim();
   end
endmodule
